// >>> rtl/kwi_params.svh
// Register offsets, field positions and reset values of the keypad interrupt unit
`ifndef KWI_PARAMS_SVH
`define KWI_PARAMS_SVH

`define KWI_STATUS_CONTROL_OFS  12'h000
`define KWI_LINE_ENABLE_OFS     12'h004
`define KWI_PIN_CONTROL_OFS     12'h008
`define KWI_PIN_LEVEL_OFS       12'h00C

`define KWI_PENDING_BIT         3
`define KWI_ACK_BIT             2
`define KWI_MASK_BIT            1
`define KWI_SENS_BIT            0

`define KWI_LINES               5
`define KWI_ENABLE_RESET        5'h00
`define KWI_DIR_RESET           5'h00

`endif

// >>> rtl/kwi_pkg.sv
// Types shared by the keypad interrupt unit
package kwi_pkg;
    typedef enum logic [1:0] {
        KWI_IDLE    = 2'b00,
        KWI_LATCHED = 2'b01,
        KWI_HOLD    = 2'b11
    } kwi_state_t;
endpackage : kwi_pkg

// >>> rtl/kwi_keypad_irq_unit.sv
// Keypad interrupt unit with APB register access
// Operation
// - Five enabled lines feed one latched request
// - Enable bit selects input and pull-up
// - Latch when enabled line falls, all were high
// - Edge mode: no latch while another low
// - Level mode: request holds while line low
// - Level mode: clear after ack and lines high
// - Vector fetch acknowledges the request
// - Ack write clears, reads zero, reset clear
// - Later falling edge latches fresh request
// - Unmasked request makes processor take vector
// - Edge mode: ack clears immediately
// - Reset clears request and sensitivity bit
// - Pending flag shows latch, ignores mask
// - Enabled line forced input; read needs dir 0
// - Upper 28 status bits read zero
// - Mask bit gates interrupt; reset clears it
// - Sensitivity: 1 edge+level, 0 edge only
// - Five enable bits, 1 enables, reset clears
// - Active in wait; request wakes from wait
// - Active in stop; request wakes from stop
// - In break without clear enable, ack ignored
`timescale 1ns/100ps
`default_nettype none
`include "kwi_params.svh"

module kwi_keypad_irq_unit #(
    parameter int LINES = `KWI_LINES
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    input  wire logic [3:0]       pstrb_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic [LINES-1:0] keypad_line_i,
    output logic      [LINES-1:0] keypad_line_o,
    output logic      [LINES-1:0] keypad_line_oe_n_o,
    output logic      [LINES-1:0] pullup_en_o,
    input  wire logic             vector_fetch_i,
    input  wire logic             break_state_i,
    input  wire logic             break_clear_enable_i,
    output logic                  irq_request_o,
    output logic                  wake_o
);

    logic [LINES-1:0] line_enable_bits;
    logic [LINES-1:0] pin_dir;
    logic [LINES-1:0] pin_data;
    logic             request_mask_bit;
    logic             sensitivity_select;
    logic [LINES-1:0] sync1;
    logic [LINES-1:0] sync2;
    logic [LINES-1:0] sync3;
    logic             any_low_prev;
    kwi_pkg::kwi_state_t state;
    logic             wr_en;
    logic             rd_en;
    logic             ack_write;
    logic             ack;
    logic             any_low;
    logic             fall;
    logic             pending_flag;
    logic             addr_ok;
    logic [LINES-1:0] level;

    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign rd_en    = psel_i & penable_i & ~pwrite_i;
    assign pready_o = 1'b1;

    always_comb begin
        if (paddr_i == `KWI_STATUS_CONTROL_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr_i == `KWI_LINE_ENABLE_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr_i == `KWI_PIN_CONTROL_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr_i == `KWI_PIN_LEVEL_OFS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr_o = psel_i & penable_i & ~addr_ok;

    // Ack during protected break has no effect
    assign ack_write = wr_en & pstrb_i[0] & (paddr_i == `KWI_STATUS_CONTROL_OFS)
                     & pwdata_i[`KWI_ACK_BIT]
                     & ~(break_state_i & ~break_clear_enable_i);
    assign ack = ack_write | vector_fetch_i;

    // Pin levels pass three flip-flops; a change counts when stages two and three agree
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= {LINES{1'b1}};
            sync2 <= {LINES{1'b1}};
            sync3 <= {LINES{1'b1}};
        end else begin
            sync1 <= keypad_line_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            // Agreed level holds its value until stages two and three match
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    level[g] <= 1'b1;
                end else if (sync2[g] == sync3[g]) begin
                    level[g] <= sync3[g];
                end
            end
            assign pullup_en_o[g]        = line_enable_bits[g];
            assign keypad_line_oe_n_o[g] = ~(pin_dir[g] & ~line_enable_bits[g]);
            assign keypad_line_o[g]      = pin_data[g];
        end
    endgenerate

    assign any_low = |(~level & line_enable_bits);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            any_low_prev <= 1'b0;
        end else begin
            any_low_prev <= any_low;
        end
    end

    // Edge counts only when every enabled line was high before
    assign fall = any_low & ~any_low_prev;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= kwi_pkg::KWI_IDLE;
        end else begin
            case (state)
                kwi_pkg::KWI_IDLE: begin
                    if (fall) begin
                        state <= kwi_pkg::KWI_LATCHED;
                    end
                end
                kwi_pkg::KWI_LATCHED: begin
                    if (fall) begin
                        state <= kwi_pkg::KWI_LATCHED;
                    end else if (ack && (!sensitivity_select || !any_low)) begin
                        state <= kwi_pkg::KWI_IDLE;
                    end else if (ack) begin
                        state <= kwi_pkg::KWI_HOLD;
                    end
                end
                kwi_pkg::KWI_HOLD: begin
                    if (fall) begin
                        state <= kwi_pkg::KWI_LATCHED;
                    end else if (!sensitivity_select || !any_low) begin
                        state <= kwi_pkg::KWI_IDLE;
                    end
                end
                default: begin
                    state <= kwi_pkg::KWI_IDLE;
                end
            endcase
        end
    end

    assign pending_flag = (state != kwi_pkg::KWI_IDLE);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            request_mask_bit   <= 1'b0;
            sensitivity_select <= 1'b0;
        end else if (wr_en && pstrb_i[0] && paddr_i == `KWI_STATUS_CONTROL_OFS) begin
            request_mask_bit   <= pwdata_i[`KWI_MASK_BIT];
            sensitivity_select <= pwdata_i[`KWI_SENS_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_enable_bits <= `KWI_ENABLE_RESET;
        end else if (wr_en && pstrb_i[0] && paddr_i == `KWI_LINE_ENABLE_OFS) begin
            line_enable_bits <= pwdata_i[LINES-1:0];
        end
    end

    // Port direction in low bits, port data in the second byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_dir  <= `KWI_DIR_RESET;
            pin_data <= `KWI_DIR_RESET;
        end else if (wr_en && paddr_i == `KWI_PIN_CONTROL_OFS) begin
            if (pstrb_i[0]) begin
                pin_dir <= pwdata_i[LINES-1:0];
            end
            if (pstrb_i[1]) begin
                pin_data <= pwdata_i[LINES+7:8];
            end
        end
    end

    // Request gated by mask drives interrupt and wake from wait or stop
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_request_o <= 1'b0;
            wake_o        <= 1'b0;
        end else begin
            irq_request_o <= pending_flag & ~request_mask_bit;
            wake_o        <= pending_flag & ~request_mask_bit;
        end
    end

    always_comb begin
        prdata_o = 32'h0000_0000;
        if (rd_en && paddr_i == `KWI_STATUS_CONTROL_OFS) begin
            prdata_o[`KWI_PENDING_BIT] = pending_flag;
            prdata_o[`KWI_MASK_BIT]    = request_mask_bit;
            prdata_o[`KWI_SENS_BIT]    = sensitivity_select;
        end else if (rd_en && paddr_i == `KWI_LINE_ENABLE_OFS) begin
            prdata_o[LINES-1:0] = line_enable_bits;
        end else if (rd_en && paddr_i == `KWI_PIN_CONTROL_OFS) begin
            prdata_o[LINES-1:0]  = pin_dir;
            prdata_o[LINES+7:8]  = pin_data;
        end else if (rd_en && paddr_i == `KWI_PIN_LEVEL_OFS) begin
            prdata_o[LINES-1:0] = level & ~pin_dir;
        end
    end

endmodule : kwi_keypad_irq_unit
`default_nettype wire

// >>> tb/kwi_keypad_model.sv
// Keypad contacts and pin pull-ups as seen at the unit's pins
`timescale 1ns/100ps
`default_nettype none
module kwi_keypad_model (
    input  wire logic       clk_i,
    input  wire logic [4:0] press_i,
    input  wire logic [4:0] pullup_en_i,
    input  wire logic [4:0] oe_n_i,
    input  wire logic [4:0] drive_i,
    output logic      [4:0] line_o
);
    logic [4:0] noise = 5'h0A;
    // A floating pin wanders
    always_ff @(posedge clk_i) noise <= ~noise;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!oe_n_i[i]) line_o[i] = drive_i[i];
            else if (press_i[i]) line_o[i] = 1'b0;
            else if (pullup_en_i[i]) line_o[i] = 1'b1;
            else line_o[i] = noise[i];
        end
    end
endmodule : kwi_keypad_model
`default_nettype wire

// >>> tb/kwi_keypad_irq_unit_monitor.sv
// Port checker for the keypad interrupt unit
`timescale 1ns/100ps
`default_nettype none
module kwi_keypad_irq_unit_checker #(
    parameter int LINES = 5
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      prdata_o,
    input  wire logic [LINES-1:0] keypad_line_i,
    input  wire logic [LINES-1:0] keypad_line_oe_n_o,
    input  wire logic [LINES-1:0] pullup_en_o,
    input  wire logic             vector_fetch_i,
    input  wire logic             irq_request_o,
    input  wire logic             wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [3:0] low_age;
    logic [3:0] ctl_age;
    logic       acc;
    logic       en_wr;
    assign acc   = psel_i && penable_i;
    assign en_wr = acc && pwrite_i && paddr_i == 12'h004;
    // Cycles since an enabled line was low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) low_age <= 4'hF;
        else if ((~keypad_line_i & pullup_en_o) != '0) low_age <= 4'h0;
        else if (low_age != 4'hF) low_age <= low_age + 4'h1;
    end
    // Cycles since a register write or a vector fetch
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) ctl_age <= 4'hF;
        else if ((acc && pwrite_i) || vector_fetch_i) ctl_age <= 4'h0;
        else if (ctl_age != 4'hF) ctl_age <= ctl_age + 4'h1;
    end
    a_wake_tracks_irq: assert property (wake_o == irq_request_o)
        else $error("wake differs from request");
    a_pullup_by_write: assert property ($changed(pullup_en_o) |->
        $past(en_wr)) else $error("pull-up moved alone");
    a_enabled_is_input: assert property ((pullup_en_o & ~keypad_line_oe_n_o) == '0)
        else $error("enabled line driven");
    a_upper_read_zero: assert property (acc && !pwrite_i && paddr_i == 12'h000 |->
        prdata_o[31:4] == 28'h000_0000) else $error("status upper bits set");
    a_ack_reads_zero: assert property (acc && !pwrite_i && paddr_i == 12'h000 |->
        !prdata_o[2]) else $error("ack bit reads one");
    a_reset_clears_all: assert property (disable iff (1'b0) !nrst_i |->
        !irq_request_o && pullup_en_o == '0) else $error("reset left state");
    a_irq_rise_cause: assert property ($rose(irq_request_o) |->
        low_age <= 4'h8 || ctl_age <= 4'h3) else $error("request without a low line");
    a_irq_fall_cause: assert property ($fell(irq_request_o) |->
        ctl_age <= 4'h8 || low_age <= 4'h8) else $error("request dropped alone");
endmodule : kwi_keypad_irq_unit_checker
`default_nettype wire
bind kwi_keypad_irq_unit kwi_keypad_irq_unit_checker #(.LINES(LINES)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .keypad_line_i(keypad_line_i), .keypad_line_oe_n_o(keypad_line_oe_n_o),
    .pullup_en_o(pullup_en_o), .vector_fetch_i(vector_fetch_i),
    .irq_request_o(irq_request_o), .wake_o(wake_o));

// >>> tb/kwi_keypad_irq_unit_test.sv
// Self-checking bench for the keypad interrupt unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module kwi_keypad_irq_unit_test;
    logic clk_i = 0, nrst_i = 1, psel = 0, pen = 0, pwr = 0, vf = 0, brk = 0, bce = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, rd, pd;
    logic [3:0] ps = 4'hF;
    logic pready, perr, err, irq, wk;
    logic [4:0] press = 0, line, lo, oen, pu;
    int miscompares = 0, check_count = 0, cyc = 0, seed = 52205, k;
    always #5 clk_i = ~clk_i;
    kwi_keypad_irq_unit dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(ps), .prdata_o(prd),
        .pready_o(pready), .pslverr_o(perr), .keypad_line_i(line), .keypad_line_o(lo),
        .keypad_line_oe_n_o(oen), .pullup_en_o(pu), .vector_fetch_i(vf), .break_state_i(brk),
        .break_clear_enable_i(bce), .irq_request_o(irq), .wake_o(wk));
    kwi_keypad_model u_keys (.clk_i(clk_i), .press_i(press), .pullup_en_i(pu), .oe_n_i(oen),
        .drive_i(lo), .line_o(line));
    task conclude;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i); psel <= 1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk_i); pen <= 1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prd; err = perr; psel <= 0; pen <= 0;
    endtask : apb
    function logic [31:0] sc(input logic p, input logic m, input logic s);
        return {28'h000_0000, p, 1'b0, m, s};
    endfunction : sc
    task st(input logic [31:0] e, input string n);
        repeat (10) @(posedge clk_i);
        apb(0, 12'h000, 0); `CHK(n, e, rd)
        $display("done: %s", n);
    endtask : st
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 3000) begin miscompares++; conclude(); end
    end
    initial begin
        // Falling reset at time zero so the asynchronous clears fire before the first edge
        nrst_i <= 1'b0;
        repeat (8) @(posedge clk_i); nrst_i <= 1;
        k = {$random(seed)} % 5;
        pd = $random(seed);
        st(sc(0, 0, 0), "status reset");
        apb(0, 12'h004, 0); `CHK("enable reset", 32'h0000_0000, rd)
        apb(0, 12'h010, 0); `CHK("unmapped", 1'b1, err)
        apb(1, 12'h000, 2); apb(1, 12'h004, 32'h0000_001F); repeat (8) @(posedge clk_i);
        apb(1, 12'h000, 6); apb(1, 12'h000, 0); `CHK("pull-ups", 5'h1F, pu)
        ps <= 4'h0; apb(1, 12'h004, 0); ps <= 4'hF;
        apb(0, 12'h004, 0); `CHK("strobe off", 32'h0000_001F, rd)
        st(sc(0, 0, 0), "setup clean");
        apb(1, 12'h008, pd); apb(0, 12'h008, 0); `CHK("pin control", pd & 32'h0000_1F1F, rd)
        `CHK("enabled input", 5'h1F, oen)
        `CHK("port data", pd[12:8], lo)
        apb(0, 12'h00C, 0); `CHK("pin level", ~pd & 32'h0000_001F, rd)
        press[k] <= 1; st(sc(1, 0, 0), "edge latch");
        `CHK("irq out", 1'b1, irq)
        `CHK("wake out", 1'b1, wk)
        @(posedge clk_i) vf <= 1; @(posedge clk_i) vf <= 0; st(sc(0, 0, 0), "fetch ack");
        press[(k + 1) % 5] <= 1; st(sc(0, 0, 0), "second low");
        press <= 0; repeat (6) @(posedge clk_i);
        press[k] <= 1; st(sc(1, 0, 0), "relatch");
        apb(1, 12'h000, 2); st(sc(1, 1, 0), "masked pending");
        `CHK("irq masked", 1'b0, irq)
        `CHK("wake masked", 1'b0, wk)
        apb(1, 12'h000, 6); st(sc(0, 1, 0), "ack write");
        press <= 0; apb(1, 12'h000, 1); press[k] <= 1; st(sc(1, 0, 1), "level latch");
        apb(1, 12'h000, 5); st(sc(1, 0, 1), "level hold");
        press <= 0; st(sc(0, 0, 1), "level clear");
        brk <= 1; press[k] <= 1; st(sc(1, 0, 1), "break latch");
        press <= 0; apb(1, 12'h000, 5); st(sc(1, 0, 1), "break ack");
        bce <= 1; apb(1, 12'h000, 5); st(sc(0, 0, 1), "break clear");
        brk <= 0; press[k] <= 1; repeat (8) @(posedge clk_i);
        `CHK("irq before reset", 1'b1, irq)
        nrst_i <= 0; repeat (2) @(posedge clk_i); nrst_i <= 1;
        st(sc(0, 0, 0), "reset clear");
        `CHK("irq after reset", 1'b0, irq)
        `CHK("pull-ups off", 5'h00, pu)
        conclude();
    end
endmodule : kwi_keypad_irq_unit_test
`default_nettype wire
